/* File: sac_conv_port.sv */
`timescale 1ns/1ns
module sac_conv_port
   import sac_pkg::*;
#(
   parameter int RES_BITS = SAC_RES_BITS,
   parameter int IN_BITS  = SAC_IN_BITS
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       sck_i,
   input  wire logic                       convert_strobe_i,
   input  wire logic                       serial_in_mode_select_i,
   input  wire logic signed [IN_BITS-1:0]  analog_sample_i,
   output logic                            serial_result_out_o,
   output logic                            serial_result_out_oe_o
);

   // ----------------------------------------------------------------
   // State of the conversion and shift sides
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SAC_SYNC_STAGES-1:0] stb_sync;
      logic [SAC_SYNC_STAGES-1:0] msel_sync;
      logic                       stb_f;
      logic                       msel_f;
      sac_phase_e                 phase;
      logic [7:0]                 cnt;
      logic [RES_BITS-1:0]        held;
      logic [RES_BITS-1:0]        code;
      logic [RES_BITS-1:0]        result;
      logic                       tag;
      logic                       cs_mode;
      logic                       busy_en;
      logic                       converting;
      logic                       pre_level;
      logic                       oe;
   } sac_conv_s;

   typedef struct packed {
      logic [RES_BITS:0]          shreg;
      logic                       seen_tag;
      logic                       long_frame;
      logic [5:0]                 edge_cnt;
   } sac_shift_s;

   localparam logic [7:0] AP_LOAD = 8'(SAC_APERTURE_CYC - 1);
   localparam logic [7:0] MSB_IDX = 8'(RES_BITS - 1);
   localparam int         AP_D    = SAC_APERTURE_CYC;
   localparam int         SAR_D   = SAC_RES_BITS;
   localparam int         CH_D    = SAC_CHAIN_DLY;

   sac_conv_s  s, next_s;
   sac_shift_s t, next_t;

   logic                rise;
   logic                enable_now;
   logic [RES_BITS-1:0] clamped;
   logic [RES_BITS-1:0] cand;
   logic                load_now;

   // Clamp over- and under-range inputs to the end codes
   function automatic logic [RES_BITS-1:0] clamp_code(
      input logic signed [IN_BITS-1:0] v
   );
      logic signed [IN_BITS-1:0] hi;
      logic signed [IN_BITS-1:0] lo;
      hi = IN_BITS'(signed'({1'b0, SAC_CODE_POS}));
      lo = IN_BITS'(signed'(SAC_CODE_NEG));
      if (v > hi) begin
         clamp_code = SAC_CODE_POS;
      end else if (v < lo) begin
         clamp_code = SAC_CODE_NEG;
      end else begin
         clamp_code = v[RES_BITS-1:0];
      end
   endfunction : clamp_code

   // ----------------------------------------------------------------
   // Conversion side, internal clock
   // ----------------------------------------------------------------
   always_comb begin
      next_s     = s;
      cand       = SAC_CODE_ZERO;
      clamped    = clamp_code(analog_sample_i);
      next_s.stb_sync  = {s.stb_sync[SAC_SYNC_STAGES-2:0], convert_strobe_i};
      next_s.msel_sync = {s.msel_sync[SAC_SYNC_STAGES-2:0],
                          serial_in_mode_select_i};
      if (s.stb_sync[1] == s.stb_sync[2]) begin
         next_s.stb_f = s.stb_sync[2];
      end
      if (s.msel_sync[1] == s.msel_sync[2]) begin
         next_s.msel_f = s.msel_sync[2];
      end
      rise       = next_s.stb_f && !s.stb_f;
      enable_now = !s.stb_f || !s.msel_f;
      unique case (s.phase)
         SAC_IDLE: begin
         end
         SAC_APERTURE: begin
            if (s.cnt == 8'h00) begin
               next_s.held  = clamped;
               next_s.code  = SAC_CODE_ZERO;
               next_s.cnt   = MSB_IDX;
               next_s.phase = SAC_CONVERT;
            end else begin
               next_s.cnt = s.cnt - 8'h01;
            end
         end
         SAC_CONVERT: begin
            // one trial bit per internal clock
            cand = s.code;
            cand[s.cnt[4:0]] = 1'b1;
            if (cand <= (s.held ^ SAC_SIGN_MASK)) begin
               next_s.code = cand;
            end
            if (s.cnt == 8'h00) begin
               // flip offset binary into two's complement
               next_s.result     = next_s.code ^ SAC_SIGN_MASK;
               next_s.tag        = !s.tag;
               next_s.converting = 1'b0;
               next_s.phase      = SAC_IDLE;
               // busy indicator armed by enable at completion
               next_s.busy_en    = s.cs_mode && enable_now;
               next_s.pre_level  = next_s.busy_en ? 1'b1
                                                  : next_s.result[RES_BITS-1];
            end else begin
               next_s.cnt = s.cnt - 8'h01;
            end
         end
      endcase
      // new conversion on every rising edge, even mid-conversion
      if (rise) begin
         next_s.cs_mode    = next_s.msel_f;
         next_s.phase      = SAC_APERTURE;
         next_s.cnt        = AP_LOAD;
         next_s.converting = 1'b1;
         next_s.pre_level  = 1'b0;
      end
      // select-gated mode: released when both strobe and serial input are high; chain mode always drives
      next_s.oe = next_s.cs_mode ? (!next_s.stb_f || !next_s.msel_f) : 1'b1;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s         <= '0;
         s.phase   <= SAC_IDLE;
         s.cs_mode <= 1'b1;
         // Filters start low, so select-gated mode starts enabled
         s.oe      <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Shift side, host shift clock
   // ----------------------------------------------------------------
   // Result, tag and busy_en only change at conversion end, while the
   // host keeps the shift clock still; they are read as static words.
   // The host must not clock during a conversion.
   assign load_now = (t.seen_tag != s.tag);

   always_comb begin
      next_t = t;
      if (t.edge_cnt != 6'h3F) begin
         next_t.edge_cnt = t.edge_cnt + 6'h01;
      end
      if (load_now) begin
         // most significant bit leads the word
         next_t.seen_tag   = s.tag;
         next_t.long_frame = s.busy_en;
         next_t.edge_cnt   = 6'h01;
         next_t.shreg      = s.busy_en
            ? {s.result, serial_in_mode_select_i}
            : {1'b0, s.result[RES_BITS-2:0], serial_in_mode_select_i};
      end else begin
         // chain data follows the result bits
         next_t.shreg = {t.shreg[RES_BITS-1:0], serial_in_mode_select_i};
      end
   end

   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         t <= '0;
      end else begin
         t <= next_t;
      end
   end

   // one bit per shift clock, busy or first bit before the frame
   assign serial_result_out_o =
      (s.converting || load_now) ? s.pre_level
      : (t.long_frame ? t.shreg[RES_BITS] : t.shreg[RES_BITS-1]);
   assign serial_result_out_oe_o = s.oe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence strobe_edge_seq;
      $rose(s.stb_f);
   endsequence

   sequence hold_seq;
      (s.phase == SAC_CONVERT) && (s.held == $past(clamped));
   endsequence

   conv_start_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      strobe_edge_seq |-> s.converting && (s.phase == SAC_APERTURE))
      else $error("strobe edge did not start a conversion");

   chain_sel_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      strobe_edge_seq and !s.msel_f |-> !s.cs_mode)
      else $error("chain mode not selected by low serial input");

   gated_sel_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      strobe_edge_seq and s.msel_f |-> s.cs_mode)
      else $error("select-gated mode not selected by high serial input");

   out_release_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s.cs_mode && s.stb_f && s.msel_f |-> !serial_result_out_oe_o)
      else $error("output driven while deselected");

   out_enable_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s.cs_mode && (!s.stb_f || !s.msel_f) |-> serial_result_out_oe_o)
      else $error("output not enabled while selected");

   busy_ind_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (s.phase == SAC_CONVERT) && (s.cnt == 8'h00) && s.cs_mode
      && (!s.stb_f || !s.msel_f) && !rise
      |=> s.busy_en && serial_result_out_o)
      else $error("busy indicator missing at conversion end");

   aperture_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      strobe_edge_seq |-> ##AP_D hold_seq)
      else $error("input not held after aperture delay");

   conv_time_a: assert property (
      @(posedge clk_i) disable iff (rst_i || rise)
      $rose(s.phase == SAC_CONVERT) |-> ##SAR_D $fell(s.converting))
      else $error("conversion length wrong");

   code_match_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(s.converting) && !$rose(s.stb_f) |-> s.result == s.held)
      else $error("result differs from held sample");

   clamp_pos_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (s.phase == SAC_APERTURE) && (s.cnt == 8'h00) && !rise
      && (analog_sample_i > IN_BITS'(signed'({1'b0, SAC_CODE_POS})))
      |=> s.held == SAC_CODE_POS)
      else $error("over-range not clamped");

   first_bits_a: assert property (
      @(posedge sck_i) disable iff (rst_i)
      load_now && !s.busy_en |=> t.shreg[RES_BITS-1] == s.result[RES_BITS-2]
      ##1 t.shreg[RES_BITS-1] == s.result[RES_BITS-3])
      else $error("result not shifted most significant bit first");

   chain_pass_a: assert property (
      @(posedge sck_i) disable iff (rst_i)
      !load_now && !t.long_frame && (t.edge_cnt > 6'(CH_D))
      |-> t.shreg[RES_BITS-1] == $past(serial_in_mode_select_i, 18))
      else $error("chain data delay wrong");

   restart_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rise |=> s.converting && (s.phase == SAC_APERTURE)
      && (s.cnt == AP_LOAD))
      else $error("strobe edge did not restart the aperture count");

   chain_drive_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !s.cs_mode |-> serial_result_out_oe_o)
      else $error("chain mode output not driven");

   busy_first_a: assert property (
      @(posedge sck_i) disable iff (rst_i)
      load_now && s.busy_en |=> t.long_frame
      && (t.shreg[RES_BITS] == s.result[RES_BITS-1]))
      else $error("busy frame does not lead with the sign bit");

endmodule : sac_conv_port

/* File: sac_pkg.sv */
package sac_pkg;

   // ----------------------------------------------------------------
   // Word format
   // ----------------------------------------------------------------
   localparam int          SAC_RES_BITS  = 18;
   localparam int          SAC_IN_BITS   = 20;
   localparam logic [17:0] SAC_CODE_POS  = 18'h1FFFF;
   localparam logic [17:0] SAC_CODE_NEG  = 18'h20000;
   localparam logic [17:0] SAC_CODE_ZERO = 18'h00000;
   localparam logic [17:0] SAC_SIGN_MASK = 18'h20000;
   localparam int          SAC_CHAIN_DLY = 18;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SAC_CLK_HZ      = 20_000_000;
   localparam int SAC_APERTURE_NS = 50;
   localparam int SAC_APERTURE_RAW =
      (SAC_APERTURE_NS * (SAC_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SAC_APERTURE_CYC =
      (SAC_APERTURE_RAW < 1) ? 1 : SAC_APERTURE_RAW;
   localparam int SAC_SYNC_STAGES = 3;

   // ----------------------------------------------------------------
   // Conversion phases
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_APERTURE,
      SAC_CONVERT
   } sac_phase_e;

endpackage : sac_pkg

/* File: sac_host.sv */
`timescale 1ns/1ns
module sac_host (
   input  wire logic clk_i,
   input  wire logic line_i,
   output logic      sck_o,
   output logic      strobe_o,
   output logic      msel_o
);
   // ---------------------------------------------------------------
   // Host side of the serial link
   // ---------------------------------------------------------------
   initial begin
      sck_o    = 1'b0;
      strobe_o = 1'b0;
      msel_o   = 1'b1;
   end

   task automatic start(input logic sel, input logic stay_high);
      @(negedge clk_i);
      strobe_o = 1'b0;
      msel_o   = sel;
      repeat (3) @(negedge clk_i);
      strobe_o = 1'b1;
      // Level kept four clocks, as long as the strobe filter latency
      repeat (4) @(negedge clk_i);
      strobe_o = stay_high;
   endtask : start

   task automatic frame(input int n, input logic [63:0] chain,
                        output logic [63:0] got);
      got    = '0;
      #7;
      got[0] = line_i;
      // Clock stands still outside frames; 48 ns period inside
      for (int k = 0; k < n; k++) begin
         msel_o = chain[k];
         #24 sck_o = 1'b1;
         #24 sck_o = 1'b0;
         got[k+1] = line_i;
      end
      msel_o = 1'b1;
   endtask : frame
endmodule : sac_host

/* File: sac_conv_port_tb.sv */
`timescale 1ns/1ns
module sac_conv_port_tb;
   import sac_pkg::*;

   logic                          clk_i;
   logic                          rst_i;
   logic                          sck;
   logic                          strobe;
   logic                          msel;
   logic                          dout;
   logic                          link_line;
   logic                          oe;
   logic signed [SAC_IN_BITS-1:0] analog;
   logic [63:0]                   got;
   int                            fail_count;
   int                            checks_done;

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   sac_conv_port DUT (
      .clk_i                  (clk_i),
      .rst_i                  (rst_i),
      .sck_i                  (sck),
      .convert_strobe_i       (strobe),
      .serial_in_mode_select_i(msel),
      .analog_sample_i        (analog),
      .serial_result_out_o    (dout),
      .serial_result_out_oe_o (oe)
   );

   // Released line shows the inverse, so a read while off is caught
   assign link_line = oe ? dout : ~dout;

   sac_host host (
      .clk_i   (clk_i),
      .line_i  (link_line),
      .sck_o   (sck),
      .strobe_o(strobe),
      .msel_o  (msel)
   );

   // ---------------------------------------------------------------
   // Compare helpers
   // ---------------------------------------------------------------
   task automatic cmp_bit(input logic a, input logic e, input string m);
      checks_done++;
      if (a !== e) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : cmp_bit

   task automatic cmp_word(input logic [17:0] a, input logic [17:0] e,
                           input string m);
      checks_done++;
      if (a !== e) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s %h", $time, m, a);
      end
   endtask : cmp_word

   function automatic logic [17:0] word_at(input logic [63:0] g,
                                           input int off);
      logic [17:0] w;
      for (int i = 0; i < 18; i++) w[17-i] = g[off+i];
      return w;
   endfunction : word_at

   // Input is scrambled after the hold so a late sample shows up
   task automatic convert(input logic signed [SAC_IN_BITS-1:0] v,
                          input logic sel, input logic stay_high);
      @(negedge clk_i);
      analog = v;
      host.start(sel, stay_high);
      repeat (1) @(negedge clk_i);
      analog = ~v;
      repeat (28) @(negedge clk_i);
   endtask : convert

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_busy;
      convert(20'sh00005, 1'b1, 1'b0);
      cmp_bit(oe, 1'b1, "enable while strobe low");
      host.frame(18, 64'hFFFF_FFFF_FFFF_FFFF, got);
      cmp_bit(got[0], 1'b1, "busy level before first clock");
      cmp_word(word_at(got, 1), 18'h00005, "busy read word");
      $display("test_busy done");
   endtask : test_busy

   task automatic test_gated(input logic signed [19:0] v,
                             input logic [17:0] e);
      convert(v, 1'b1, 1'b1);
      cmp_bit(oe, 1'b0, "released while deselected");
      @(negedge clk_i);
      host.msel_o = 1'b0;
      repeat (6) @(negedge clk_i);
      cmp_bit(oe, 1'b1, "enabled by serial input low");
      host.msel_o   = 1'b1;
      host.strobe_o = 1'b0;
      repeat (6) @(negedge clk_i);
      host.frame(18, 64'hFFFF_FFFF_FFFF_FFFF, got);
      cmp_word(word_at(got, 0), e, "gated read word");
      $display("test_gated done");
   endtask : test_gated

   task automatic test_chain;
      logic [63:0] pat;
      pat = 64'h0000_00A5_3C96_C3A5;
      convert(20'sh12345, 1'b0, 1'b1);
      cmp_bit(oe, 1'b1, "chain output driven");
      host.frame(40, pat, got);
      cmp_word(word_at(got, 0), 18'h12345, "chain own word");
      for (int j = 0; j < 22; j++) begin
         cmp_bit(got[18+j], pat[j], "chain data delayed");
      end
      $display("test_chain done");
   endtask : test_chain

   task automatic results;
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   initial begin
      fail_count  = 0;
      checks_done = 0;
      rst_i       = 1'b1;
      analog      = '0;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (5) @(negedge clk_i);
      test_busy();
      test_gated(20'sh7FFFF, SAC_CODE_POS);
      test_gated(20'sh80000, SAC_CODE_NEG);
      test_gated(20'shFFFFF, 18'h3FFFF);
      test_gated(20'sh00000, SAC_CODE_ZERO);
      test_chain();
      results();
   end

   // Run needs about 420 cycles; this span is far beyond it
   initial begin
      #1_000_000;
      fail_count++;
      results();
   end
endmodule : sac_conv_port_tb
